// ==== tws_device.sv ====
// tws_device.sv: two-wire register slave end, runs on the link clock
// assumes: link_clk_i oversamples the serial clock; host keeps the link rules
// Function
// - slave only, clock is input only
// - register address always sixteen bits
// - both lines high means bus idle
// - data falls, clock high: start
// - data rises, clock high: stop
// - host makes start/stop, repeated start accepted
// - eight bits msb first, then ack
// - data changes only while clock low
// - address byte: seven address bits, direction
// - select pin picks 0x90/0x91 or 0xBA/0xBB
// - acknowledge only own address, else release
// - transmitter releases, receiver pulls low
// - high in ack slot means no-ack
// - two register address bytes, each acknowledged
// - address increments after each written byte
// - host ends write with stop/restart
// - random read: address write, restart, read
// - read: increment per byte, nack ends
// - host ends direct writes with stop
// - register address high byte first
// - bare read uses current internal address
`timescale 1ns/1ns
`default_nettype none
`include "tws_regs.svh"
module tws_device #(
  parameter int MEM_AW = 8,
  parameter int FILT = `TWS_FILT_LEN
) (
  input wire logic link_clk_i,
  input wire logic rst_n_i,
  tws_if.dev link,
  input wire logic address_select_pin_i,
  input wire logic [MEM_AW-1:0] user_addr_i,
  output logic [7:0] user_data_o,
  output logic wr_pulse_o,
  output logic [15:0] wr_addr_o,
  output logic [7:0] wr_data_o,
  output logic selected_o
);
  logic [1:0] rst_pipe;
  logic rst_n;
  logic scl;
  logic sda;
  logic sel;
  logic scl_q;
  logic sda_q;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic [6:0] own_addr;
  tws_pkg::tws_dev_state_t state;
  tws_pkg::tws_rx_phase_t phase;
  logic [3:0] cnt;
  logic [7:0] shreg;
  logic [7:0] tx;
  logic [15:0] ptr;
  logic drive_low;
  logic host_acked;
  logic [7:0] mem [0:(1<<MEM_AW)-1];
  logic do_write;

  // ---------------------------------------------------------------
  // reset release in the link domain
  // ---------------------------------------------------------------
  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  // ---------------------------------------------------------------
  // line conditioning
  // ---------------------------------------------------------------
  tws_sync_filt #(.FILT(FILT), .RST_VAL(1'b1)) u_scl (
    .clk_i(link_clk_i),
    .rst_n_i(rst_n),
    .d_i(link.scl),
    .q_o(scl)
  );
  tws_sync_filt #(.FILT(FILT), .RST_VAL(1'b1)) u_sda (
    .clk_i(link_clk_i),
    .rst_n_i(rst_n),
    .d_i(link.sda),
    .q_o(sda)
  );
  tws_sync_filt #(.FILT(FILT), .RST_VAL(1'b0)) u_sel (
    .clk_i(link_clk_i),
    .rst_n_i(rst_n),
    .d_i(address_select_pin_i),
    .q_o(sel)
  );

  always_ff @(posedge link_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  assign scl_rise = scl & ~scl_q;
  assign scl_fall = ~scl & scl_q;
  assign start_cond = scl & scl_q & sda_q & ~sda;
  assign stop_cond = scl & scl_q & ~sda_q & sda;
  assign own_addr = sel ? 7'(`TWS_ADDR_BYTE_SEL1 >> 1) : 7'(`TWS_ADDR_BYTE_SEL0 >> 1);

  // ---------------------------------------------------------------
  // protocol state machine
  // ---------------------------------------------------------------
  always_ff @(posedge link_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= tws_pkg::DS_IDLE;
      phase <= tws_pkg::PH_ADDR;
      cnt <= 4'h0;
      shreg <= 8'h00;
      tx <= 8'h00;
      ptr <= `TWS_PTR_RST;
      drive_low <= 1'b0;
      host_acked <= 1'b0;
    end else if (stop_cond) begin
      state <= tws_pkg::DS_IDLE;
      drive_low <= 1'b0;
    end else if (start_cond) begin
      state <= tws_pkg::DS_RECV;
      phase <= tws_pkg::PH_ADDR;
      cnt <= 4'h0;
      drive_low <= 1'b0;
    end else begin
      unique case (state)
        tws_pkg::DS_IDLE, tws_pkg::DS_WAIT: begin
          drive_low <= 1'b0;
        end
        tws_pkg::DS_RECV: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], sda};
            cnt <= cnt + 4'h1;
          end else if (scl_fall && cnt == `TWS_BYTE_BITS) begin
            cnt <= 4'h0;
            state <= tws_pkg::DS_RACK;
            drive_low <= 1'b1;
            unique case (phase)
              tws_pkg::PH_ADDR: begin
                if (shreg[7:1] != own_addr) begin
                  state <= tws_pkg::DS_WAIT;
                  drive_low <= 1'b0;
                end
              end
              tws_pkg::PH_REGHI: ptr[15:8] <= shreg;
              tws_pkg::PH_REGLO: ptr[7:0] <= shreg;
              tws_pkg::PH_DATA: ptr <= ptr + 16'h0001;
            endcase
          end
        end
        tws_pkg::DS_RACK: begin
          if (scl_fall) begin
            drive_low <= 1'b0;
            state <= tws_pkg::DS_RECV;
            unique case (phase)
              tws_pkg::PH_ADDR: begin
                if (shreg[0]) begin
                  state <= tws_pkg::DS_SEND;
                  tx <= {mem[ptr[MEM_AW-1:0]][6:0], 1'b0};
                  drive_low <= ~mem[ptr[MEM_AW-1:0]][7];
                  cnt <= 4'h1;
                end else begin
                  phase <= tws_pkg::PH_REGHI;
                end
              end
              tws_pkg::PH_REGHI: phase <= tws_pkg::PH_REGLO;
              tws_pkg::PH_REGLO: phase <= tws_pkg::PH_DATA;
              tws_pkg::PH_DATA: phase <= tws_pkg::PH_DATA;
            endcase
          end
        end
        tws_pkg::DS_SEND: begin
          if (scl_fall) begin
            if (cnt == `TWS_BYTE_BITS) begin
              state <= tws_pkg::DS_TACK;
              drive_low <= 1'b0;
              ptr <= ptr + 16'h0001;
            end else begin
              drive_low <= ~tx[7];
              tx <= {tx[6:0], 1'b0};
              cnt <= cnt + 4'h1;
            end
          end
        end
        tws_pkg::DS_TACK: begin
          if (scl_rise) begin
            host_acked <= ~sda;
            state <= tws_pkg::DS_HACK;
          end
        end
        tws_pkg::DS_HACK: begin
          if (scl_fall) begin
            if (host_acked) begin
              state <= tws_pkg::DS_SEND;
              tx <= {mem[ptr[MEM_AW-1:0]][6:0], 1'b0};
              drive_low <= ~mem[ptr[MEM_AW-1:0]][7];
              cnt <= 4'h1;
            end else begin
              state <= tws_pkg::DS_WAIT;
            end
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // register store and write report
  // ---------------------------------------------------------------
  assign do_write = ~stop_cond & ~start_cond & scl_fall & (state == tws_pkg::DS_RECV)
    & (phase == tws_pkg::PH_DATA) & (cnt == `TWS_BYTE_BITS);

  always_ff @(posedge link_clk_i) begin
    if (do_write) begin
      mem[ptr[MEM_AW-1:0]] <= shreg;
    end
    user_data_o <= mem[user_addr_i];
  end

  always_ff @(posedge link_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wr_pulse_o <= 1'b0;
      wr_addr_o <= 16'h0000;
      wr_data_o <= 8'h00;
    end else begin
      wr_pulse_o <= do_write;
      if (do_write) begin
        wr_addr_o <= ptr;
        wr_data_o <= shreg;
      end
    end
  end

  // ---------------------------------------------------------------
  // pin drive: open drain data, never the clock
  // ---------------------------------------------------------------
  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe = drive_low;
  assign selected_o = ~(state == tws_pkg::DS_IDLE || state == tws_pkg::DS_WAIT);
endmodule // tws_device
`default_nettype wire

// ==== tws_host.sv ====
// tws_host.sv: two-wire bus master end, makes the serial clock
// assumes: one slave on the link; commands come one at a time
`timescale 1ns/1ns
`default_nettype none
`include "tws_regs.svh"
module tws_host #(
  parameter int QTR_CYC = `TWS_SCL_QTR_CYC
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  tws_if.host link,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire tws_pkg::tws_cmd_t cmd_i,
  input wire logic [7:0] cmd_data_i,
  input wire logic cmd_ack_i,
  output logic done_o,
  output logic [7:0] rd_data_o,
  output logic ack_seen_o
);
  tws_pkg::tws_host_state_t state;
  logic [15:0] qcnt;
  logic tick;
  logic [1:0] ph;
  logic [3:0] bitn;
  logic [7:0] sh;
  logic rd;
  logic mack;
  logic scl;
  logic oe;
  logic [1:0] sda_sync;

  assign cmd_ready_o = (state == tws_pkg::HS_IDLE);
  assign tick = (state != tws_pkg::HS_IDLE) && (qcnt == 16'(QTR_CYC - 1));

  // ---------------------------------------------------------------
  // data line synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sda_sync <= 2'h3;
    end else begin
      sda_sync <= {sda_sync[0], link.sda};
    end
  end

  // ---------------------------------------------------------------
  // quarter period divider
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      qcnt <= 16'h0000;
    end else if (state == tws_pkg::HS_IDLE || tick) begin
      qcnt <= 16'h0000;
    end else begin
      qcnt <= qcnt + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // command sequencer, four phases per bit
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= tws_pkg::HS_IDLE;
      ph <= 2'h0;
      bitn <= 4'h0;
      sh <= 8'h00;
      rd <= 1'b0;
      mack <= 1'b0;
      scl <= 1'b1;
      oe <= 1'b0;
      done_o <= 1'b0;
      rd_data_o <= 8'h00;
      ack_seen_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      unique case (state)
        tws_pkg::HS_IDLE: begin
          if (cmd_valid_i) begin
            ph <= 2'h0;
            bitn <= 4'h0;
            sh <= cmd_data_i;
            rd <= (cmd_i == tws_pkg::CMD_READ);
            mack <= cmd_ack_i;
            unique case (cmd_i)
              tws_pkg::CMD_START: state <= tws_pkg::HS_START;
              tws_pkg::CMD_STOP: state <= tws_pkg::HS_STOP;
              default: state <= tws_pkg::HS_BIT;
            endcase
          end
        end
        tws_pkg::HS_START: begin
          if (tick) begin
            ph <= ph + 2'h1;
            unique case (ph)
              2'h0: oe <= 1'b0;
              2'h1: scl <= 1'b1;
              2'h2: oe <= 1'b1;
              2'h3: begin
                scl <= 1'b0;
                state <= tws_pkg::HS_IDLE;
                done_o <= 1'b1;
              end
            endcase
          end
        end
        tws_pkg::HS_STOP: begin
          if (tick) begin
            ph <= ph + 2'h1;
            unique case (ph)
              2'h0: oe <= 1'b1;
              2'h1: scl <= 1'b1;
              2'h2: oe <= 1'b0;
              2'h3: begin
                state <= tws_pkg::HS_IDLE;
                done_o <= 1'b1;
              end
            endcase
          end
        end
        tws_pkg::HS_BIT: begin
          if (tick) begin
            ph <= ph + 2'h1;
            unique case (ph)
              2'h0: begin
                if (bitn == `TWS_ACK_BIT) begin
                  oe <= rd & mack;
                end else begin
                  oe <= ~rd & ~sh[7];
                end
              end
              2'h1: scl <= 1'b1;
              2'h2: begin
                if (bitn == `TWS_ACK_BIT) begin
                  ack_seen_o <= ~sda_sync[1];
                end else begin
                  sh <= {sh[6:0], sda_sync[1]};
                end
              end
              2'h3: begin
                scl <= 1'b0;
                if (bitn == `TWS_ACK_BIT) begin
                  state <= tws_pkg::HS_IDLE;
                  done_o <= 1'b1;
                  rd_data_o <= sh;
                end else begin
                  bitn <= bitn + 4'h1;
                end
              end
            endcase
          end
        end
      endcase
    end
  end

  assign link.scl = scl;
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe = oe;
endmodule // tws_host
`default_nettype wire

// ==== tws_if.sv ====
// tws_if.sv: the two-wire link between host master and register slave
// assumes: open-drain data line with pull-up; clock driven by the host only
`timescale 1ns/1ns
`default_nettype none
interface tws_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;

  // ---------------------------------------------------------------
  // wired-and data line, pulled high when nobody drives
  // ---------------------------------------------------------------
  assign sda = (host_sda_oe ? host_sda_o : 1'b1) & (dev_sda_oe ? dev_sda_o : 1'b1);

  modport host (output scl, output host_sda_o, output host_sda_oe, input sda);
  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
endinterface
`default_nettype wire

// ==== tws_link_assertions.sv ====
// tws_link_assertions.sv: link checks for the two-wire register slave
// assumes: placed beside tws_if, sampled on the host reference clock
`timescale 1ns/1ns
`default_nettype none
module tws_link_assertions (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic address_select_pin_i,
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_oe
);
  // ---------------------------------------------------------------
  // line history and byte tracking
  // ---------------------------------------------------------------
  logic scl_q, sda_q, first, ok, rd, nacked, rise, start, stop;
  logic [3:0] cnt;
  logic [7:0] sh, own;
  assign rise = scl && !scl_q;
  assign start = scl && scl_q && sda_q && !sda;
  assign stop = scl && scl_q && !sda_q && sda;
  assign own = address_select_pin_i ? 8'hBA : 8'h90;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= 4'h0;
      sh <= 8'h00;
      first <= 1'b0;
      ok <= 1'b0;
      rd <= 1'b0;
      nacked <= 1'b0;
    end else if (start || stop) begin
      cnt <= 4'h0;
      first <= start;
      ok <= 1'b0;
      nacked <= 1'b0;
    end else if (rise && cnt != 4'h8) begin
      sh <= {sh[6:0], sda};
      cnt <= cnt + 4'h1;
    end else if (rise) begin
      cnt <= 4'h0;
      first <= 1'b0;
      if (first) ok <= !sda;
      if (first) rd <= sh[0];
      if (!first && ok && rd && sda) nacked <= 1'b1;
    end
  end
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  addr_ack_a: assert property (rise && cnt == 4'h8 && first |-> sda == (sh[7:1] != own[7:1]))
    else $error("address byte answered wrongly");
  write_ack_a: assert property (rise && cnt == 4'h8 && !first && ok && !rd |-> !sda)
    else $error("written byte not acknowledged");
  read_release_a: assert property (rise && cnt == 4'h8 && !first && ok && rd |-> !dev_sda_oe)
    else $error("device drives host ack slot");
  foreign_quiet_a: assert property (rise && cnt == 4'h8 && !first && !ok |-> sda)
    else $error("unaddressed device acknowledged");
  high_stable_a: assert property (scl && scl_q |-> $stable(dev_sda_oe))
    else $error("device data changed while clock high");
  ack_hold_a: assert property (rise && dev_sda_oe |-> dev_sda_oe [*8])
    else $error("device drive dropped early");
  nack_quiet_a: assert property (nacked |-> !dev_sda_oe)
    else $error("device sends after host no-ack");
  start_free_a: assert property (start |-> !dev_sda_oe)
    else $error("device drives at start");
  stop_idle_a: assert property (stop |=> !dev_sda_oe [*8])
    else $error("device drives after stop");
endmodule // tws_link_assertions
`default_nettype wire

// ==== tws_pkg.sv ====
// tws_pkg.sv: types of the two-wire register slave link
// assumes: nothing beyond the compile order
package tws_pkg;

  typedef enum logic [6:0] {
    DS_IDLE = 7'h01,
    DS_RECV = 7'h02,
    DS_RACK = 7'h04,
    DS_SEND = 7'h08,
    DS_TACK = 7'h10,
    DS_WAIT = 7'h20,
    DS_HACK = 7'h40
  } tws_dev_state_t;

  typedef enum logic [3:0] {
    PH_ADDR = 4'h1,
    PH_REGHI = 4'h2,
    PH_REGLO = 4'h4,
    PH_DATA = 4'h8
  } tws_rx_phase_t;

  typedef enum logic [3:0] {
    HS_IDLE = 4'h1,
    HS_START = 4'h2,
    HS_STOP = 4'h4,
    HS_BIT = 4'h8
  } tws_host_state_t;

  typedef enum logic [1:0] {
    CMD_START = 2'h0,
    CMD_STOP = 2'h1,
    CMD_WRITE = 2'h2,
    CMD_READ = 2'h3
  } tws_cmd_t;

endpackage

// ==== tws_regs.svh ====
// tws_regs.svh: constants of the two-wire register slave link
// assumes: included by bare name; ref clock 125 MHz, link clock 32 ns
`ifndef TWS_REGS_SVH
`define TWS_REGS_SVH

// slave address/direction bytes for each level of the select pin
`define TWS_ADDR_BYTE_SEL0 8'h90
`define TWS_ADDR_BYTE_SEL1 8'hBA
`define TWS_BYTE_BITS 4'h8
`define TWS_ACK_BIT 4'h8
`define TWS_PTR_RST 16'h0000
// reference clock period and serial clock quarter period
`define TWS_REF_PERIOD_NS 8
`define TWS_SCL_QTR_NS 625
`define TWS_SCL_QTR_CYC ((`TWS_SCL_QTR_NS + `TWS_REF_PERIOD_NS - 1) / `TWS_REF_PERIOD_NS)
// equal samples needed before a filtered line changes
`define TWS_FILT_LEN 3

`endif

// ==== tws_sync_filt.sv ====
// tws_sync_filt.sv: two-flop synchroniser followed by a stability filter
// assumes: d_i is asynchronous to clk_i
`timescale 1ns/1ns
`default_nettype none
module tws_sync_filt #(
  parameter int FILT = 3,
  parameter logic RST_VAL = 1'b1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic d_i,
  output logic q_o
);
  logic [1:0] sync;
  logic [FILT-1:0] hist;

  // ---------------------------------------------------------------
  // synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync <= {2{RST_VAL}};
    end else begin
      sync <= {sync[0], d_i};
    end
  end

  // ---------------------------------------------------------------
  // filter: output follows only after FILT equal samples
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hist <= {FILT{RST_VAL}};
    end else begin
      hist <= {hist[FILT-2:0], sync[1]};
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_o <= RST_VAL;
    end else if (&hist) begin
      q_o <= 1'b1;
    end else if (~|hist) begin
      q_o <= 1'b0;
    end
  end
endmodule // tws_sync_filt
`default_nettype wire

// ==== tws_two_wire_register_slave_test.sv ====
// tws_two_wire_register_slave_test.sv: self-checking bench, host facing device
// assumes: 125 MHz host clock, 32 ns link clock, shortened serial clock
`timescale 1ns/1ns
`default_nettype none
`include "tws_regs.svh"
module tws_two_wire_register_slave_test;
  logic ref_clk_i = 1'b0;
  logic link_clk = 1'b0;
  logic rst_n_i = 1'b0;
  logic sel = 1'b0;
  logic cmd_valid = 1'b0;
  tws_pkg::tws_cmd_t cmd = tws_pkg::CMD_START;
  logic [7:0] cmd_data = 8'h00;
  logic cmd_ack = 1'b0;
  logic done, ack_seen, wr_pulse;
  logic [7:0] rd_data, wr_data;
  logic [15:0] wr_addr;
  logic ready, selected;
  logic [7:0] user_addr = 8'h00;
  logic [7:0] user_data;
  logic [9:0] e;
  int miscompares = 0;
  int checked = 0;
  logic [23:0] wq[$];
  logic [9:0] hq[$];
  // ---------------------------------------------------------------
  // both ends, link and checker
  // ---------------------------------------------------------------
  tws_if u_tws_if ();
  tws_device u_tws_device (.link_clk_i(link_clk), .rst_n_i(rst_n_i), .link(u_tws_if.dev),
    .address_select_pin_i(sel), .user_addr_i(user_addr), .user_data_o(user_data),
    .wr_pulse_o(wr_pulse), .wr_addr_o(wr_addr), .wr_data_o(wr_data), .selected_o(selected));
  tws_host #(.QTR_CYC(40)) u_tws_host (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .link(u_tws_if.host), .cmd_valid_i(cmd_valid), .cmd_ready_o(ready), .cmd_i(cmd),
    .cmd_data_i(cmd_data), .cmd_ack_i(cmd_ack), .done_o(done), .rd_data_o(rd_data),
    .ack_seen_o(ack_seen));
  tws_link_assertions u_tws_link_assertions (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .address_select_pin_i(sel), .scl(u_tws_if.scl), .sda(u_tws_if.sda),
    .dev_sda_oe(u_tws_if.dev_sda_oe));
  initial forever #4 ref_clk_i = ~ref_clk_i;
  initial begin
    #3;
    forever #16 link_clk = ~link_clk;
  end
  // ---------------------------------------------------------------
  // compare, close, commands
  // ---------------------------------------------------------------
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic op(input tws_pkg::tws_cmd_t c, input logic [7:0] d, input logic a,
                    input logic [9:0] x);
    int n;
    hq.push_back(x);
    cmd_valid <= 1'b1;
    cmd <= c;
    cmd_data <= d;
    cmd_ack <= a;
    @(posedge ref_clk_i);
    cmd_valid <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 4000) begin
      @(negedge ref_clk_i);
      n++;
    end
    if (n >= 4000) begin
      miscompares++;
      finish_test();
    end
    repeat (2) @(posedge ref_clk_i);
  endtask
  task automatic ctl(input tws_pkg::tws_cmd_t c);
    op(c, 8'h00, 1'b0, 10'h000);
  endtask
  task automatic wb(input logic [7:0] d, input logic a);
    op(tws_pkg::CMD_WRITE, d, 1'b0, {2'h1, 7'h00, a});
  endtask
  task automatic rb(input logic a, input logic [7:0] d);
    op(tws_pkg::CMD_READ, 8'hFF, a, {2'h2, d});
  endtask
  // ---------------------------------------------------------------
  // result watchers
  // ---------------------------------------------------------------
  always @(negedge ref_clk_i) begin
    if (done === 1'b1) begin
      e = (hq.size() > 0) ? hq.pop_front() : 10'h300;
      if (e[9:8] == 2'h3) check(24'h1, 24'h0);
      if (e[9:8] == 2'h1) check({23'h0, ack_seen}, {23'h0, e[0]});
      if (e[9:8] == 2'h1) check({23'h0, selected}, {23'h0, e[0]});
      if (e[9:8] == 2'h2) check({16'h0, rd_data}, {16'h0, e[7:0]});
    end else if (hq.size() > 0 && cmd_valid === 1'b0) begin
      check({23'h0, ready}, 24'h0);
    end
  end
  always @(negedge link_clk) begin
    if (wr_pulse === 1'b1) begin
      if (wq.size() == 0) check(24'h1, 24'h0);
      else check({wr_addr, wr_data}, wq.pop_front());
    end
  end
  initial begin
    repeat (90000) @(posedge ref_clk_i);
    miscompares++;
    finish_test();
  end
  // ---------------------------------------------------------------
  // scenarios: write burst across a byte carry, random, bare, foreign
  // ---------------------------------------------------------------
  initial begin
    logic [15:0] base;
    logic [7:0] d [4];
    logic [7:0] own;
    int k;
    int i;
    void'($urandom(32'h19FDA03C));
    repeat (4) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    for (k = 0; k < 2; k++) begin
      @(posedge ref_clk_i);
      sel <= k[0];
      own = k[0] ? `TWS_ADDR_BYTE_SEL1 : `TWS_ADDR_BYTE_SEL0;
      repeat (60) @(posedge ref_clk_i);
      base = {8'($urandom()), 8'hFE};
      ctl(tws_pkg::CMD_START);
      wb(own, 1'b1);
      wb(base[15:8], 1'b1);
      wb(base[7:0], 1'b1);
      for (i = 0; i < 4; i++) begin
        d[i] = 8'($urandom());
        wq.push_back({base + 16'(i), d[i]});
        wb(d[i], 1'b1);
      end
      ctl(tws_pkg::CMD_START);
      wb(own, 1'b1);
      wb(base[15:8], 1'b1);
      wb(base[7:0], 1'b1);
      ctl(tws_pkg::CMD_START);
      wb(own | 8'h01, 1'b1);
      for (i = 0; i < 3; i++) rb(i < 2, d[i]);
      ctl(tws_pkg::CMD_STOP);
      ctl(tws_pkg::CMD_START);
      wb(own | 8'h01, 1'b1);
      rb(1'b0, d[3]);
      ctl(tws_pkg::CMD_STOP);
      for (i = 0; i < 4; i++) begin
        user_addr <= base[7:0] + 8'(i);
        repeat (12) @(posedge ref_clk_i);
        check({16'h0, user_data}, {16'h0, d[i]});
      end
      ctl(tws_pkg::CMD_START);
      wb(k[0] ? `TWS_ADDR_BYTE_SEL0 : `TWS_ADDR_BYTE_SEL1, 1'b0);
      wb(8'($urandom()), 1'b0);
      ctl(tws_pkg::CMD_STOP);
    end
    check(24'(wq.size() + hq.size()), 24'h0);
    finish_test();
  end
endmodule // tws_two_wire_register_slave_test
`default_nettype wire
